/* frf_top.sv */
// floating-point register file with status/control and cpu transfer registers
`timescale 1ns/1ps
`include "frf_cfg.svh"

// Overview of operation
// RULE1 - thirty-two 32-bit registers in two banks
// RULE2 - single view follows the bank-select bit
// RULE3 - extended single view uses the opposite bank
// RULE4 - double view: even upper, odd lower
// RULE5 - vectors are four registers from 0/4/8/12
// RULE6 - extended doubles pair extended singles likewise
// RULE7 - matrix columns hold extended 4k to 4k+3
// RULE8 - control resets to denormal flush, round-to-zero
// RULE9 - size, precision, denormal, rounding at fixed bits
// RULE10 - six cause bits at 17 down to 12
// RULE11 - five enable bits, none for error
// RULE12 - five sticky flag bits, none for error
// RULE13 - transfer-size bit picks 32 or 64-bit moves
// RULE14 - precision bit picks single or double arithmetic
// RULE15 - software never sets size and precision together
// RULE16 - denormal bit set flushes denormals to zero
// RULE17 - each operation start clears all cause bits
// RULE18 - exception sets cause and sticky flag
// RULE19 - rounding 00 nearest, 01 zero, others reserved
// RULE20 - bits 31 to 22 read zero
// RULE21 - 32-bit transfer register loaded and stored by cpu
// RULE22 - absent source clears cause, keeps flag
// RULE23 - fpu disabled refuses instructions, raises exception
// RULE24 - bank change applies to later instructions
module frf_top (
  input  wire logic                 sys_clk,       // core clock, 250 MHz
  input  wire logic                 nrst,          // async reset, active low
  input  wire logic                 fpuDisableBit, // processor fpu-disable bit
  input  wire logic                 opStart,       // an fpu operation begins
  input  wire logic                 excValid,      // operation reports its sources
  input  wire frf_pkg::frf_exc_t    excSrc,        // sources that occurred
  input  wire logic                 wrEn,          // register write request
  input  wire frf_pkg::frf_wr_req_t wrReq,         // view, index and data to write
  input  wire logic                 rdEn,          // register read request
  input  wire frf_pkg::frf_view_t   rdView,        // view to read
  input  wire logic [3:0]           rdIdx,         // register or column number
  input  wire logic                 ctrlLoad,      // load status/control
  input  wire logic [31:0]          ctrlLoadData,  // value to load
  input  wire logic                 xferLoad,      // load transfer register
  input  wire logic [31:0]          xferLoadData,  // value to load
  input  wire logic                 bankToggle,    // flip the bank-select bit
  output logic                      rdValid,       // read data valid, one cycle
  output logic      [127:0]         rdData,        // read data
  output logic      [31:0]          ctrlData,      // status/control register
  output logic      [31:0]          xferData,      // transfer register
  output frf_pkg::frf_mode_t        mode,          // decoded modes
  output logic                      disableExc     // refused instruction, one cycle
);

  // =====================================================================
  // state
  logic [31:0]  ctrl_r;        // fpu_status_control
  logic [31:0]  ctrl_nxt;      // its next value
  logic [31:0]  xfer_r;        // fpu_cpu_transfer
  logic         rdValid_r;     // read answer strobe
  logic [127:0] rdData_r;      // read answer data
  logic         disableExc_r;  // refusal strobe
  logic [511:0] bank0Flat;     // bank 0 contents
  logic [511:0] bank1Flat;     // bank 1 contents
  logic [127:0] viewData;      // gathered read words

  // =====================================================================
  // request gating: a set fpu-disable bit refuses every request
  wire anyReq      = opStart | excValid | wrEn | rdEn | ctrlLoad | xferLoad | bankToggle;
  wire opStartOk   = opStart & ~fpuDisableBit;     // RULE23
  wire excValidOk  = excValid & ~fpuDisableBit;    // RULE23
  wire wrEnOk      = wrEn & ~fpuDisableBit;        // RULE23
  wire rdEnOk      = rdEn & ~fpuDisableBit;        // RULE23
  wire ctrlLoadOk  = ctrlLoad & ~fpuDisableBit;    // RULE23
  wire xferLoadOk  = xferLoad & ~fpuDisableBit;    // RULE23
  wire bankToggleOk = bankToggle & ~fpuDisableBit; // RULE23

  // =====================================================================
  // mode decode from the stored control word
  wire       bankSwap = ctrl_r[`FRF_BIT_BANK];
  wire       pairMove = ctrl_r[`FRF_BIT_SIZE];                  // RULE13
  wire [1:0] rmField  = ctrl_r[`FRF_RM_HI:`FRF_RM_LO];          // RULE9

  assign mode.bankSwap      = bankSwap;
  assign mode.pairMove      = pairMove;                         // RULE13
  assign mode.doublePrec    = ctrl_r[`FRF_BIT_PREC];            // RULE14
  assign mode.flushDenorm   = ctrl_r[`FRF_BIT_DENORM];          // RULE16
  assign mode.roundToZero   = (rmField == `FRF_RM_ZERO);        // RULE19
  assign mode.roundReserved = (rmField != `FRF_RM_NEAREST) &&
                              (rmField != `FRF_RM_ZERO);        // RULE19
  // the arithmetic side must treat this as undefined operation
  assign mode.comboReserved = pairMove & ctrl_r[`FRF_BIT_PREC]; // RULE15

  // =====================================================================
  // write decode onto physical banks
  wire isExtWr  = (wrReq.view == frf_pkg::FRF_VIEW_EXT_SINGLE) ||
                  (wrReq.view == frf_pkg::FRF_VIEW_EXT_DOUBLE);
  wire isDblWr  = (wrReq.view == frf_pkg::FRF_VIEW_DOUBLE) ||
                  (wrReq.view == frf_pkg::FRF_VIEW_EXT_DOUBLE);
  wire isWide   = isDblWr || pairMove;                          // RULE13
  wire wrBank1  = bankSwap ^ isExtWr;                           // RULE2 RULE3
  wire legalWr  = (wrReq.view != frf_pkg::FRF_VIEW_VECTOR) &&
                  (wrReq.view != frf_pkg::FRF_VIEW_MATRIX);
  wire wrGo     = wrEnOk && legalWr;
  // wide writes put the upper word in the even register
  wire wrEven   = wrGo && (isWide || !wrReq.idx[0]);            // RULE4 RULE6
  wire wrOdd    = wrGo && (isWide || wrReq.idx[0]);             // RULE4 RULE6
  wire [31:0] evenData = isWide ? wrReq.data[63:32] : wrReq.data[31:0];
  wire [31:0] oddData  = wrReq.data[31:0];

  // =====================================================================
  // physical banks
  frf_bank uBank0 (                                             // RULE1
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .wrEvenEn   (wrEven && !wrBank1),
    .wrOddEn    (wrOdd && !wrBank1),
    .wrPair     (wrReq.idx[3:1]),
    .wrEvenData (evenData),
    .wrOddData  (oddData),
    .regsFlat   (bank0Flat)
  );

  frf_bank uBank1 (                                             // RULE1
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .wrEvenEn   (wrEven && wrBank1),
    .wrOddEn    (wrOdd && wrBank1),
    .wrPair     (wrReq.idx[3:1]),
    .wrEvenData (evenData),
    .wrOddData  (oddData),
    .regsFlat   (bank1Flat)
  );

  // read side view mapping
  frf_view_sel uViewSel (                                       // RULE5 RULE7
    .bankSwap  (bankSwap),
    .pairMove  (pairMove),
    .view      (rdView),
    .idx       (rdIdx),
    .bank0Flat (bank0Flat),
    .bank1Flat (bank1Flat),
    .viewData  (viewData)
  );

  // =====================================================================
  // status/control next value
  always_comb begin
    ctrl_nxt = ctrl_r;
    // register swap instruction flips the bank in one cycle
    if (bankToggleOk) begin
      ctrl_nxt[`FRF_BIT_BANK] = ~ctrl_r[`FRF_BIT_BANK];         // RULE24
    end
    // load from the cpu, reserved bits forced to zero
    if (ctrlLoadOk) begin
      ctrl_nxt = ctrlLoadData & `FRF_CTRL_WMASK;                // RULE20
    end
    // a new operation starts with an empty cause field
    if (opStartOk) begin
      ctrl_nxt[`FRF_CAUSE_HI:`FRF_CAUSE_LO] = 6'h00;            // RULE17
    end
    // reported sources: cause mirrors them, flags accumulate
    if (excValidOk) begin
      ctrl_nxt[`FRF_CAUSE_HI:`FRF_CAUSE_LO] = excSrc;           // RULE10 RULE18 RULE22
      ctrl_nxt[`FRF_FLAG_HI:`FRF_FLAG_LO] = ctrl_nxt[`FRF_FLAG_HI:`FRF_FLAG_LO] |
                                            excSrc[4:0];       // RULE12 RULE18
    end
  end

  // control register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= `FRF_CTRL_RESET;                                // RULE8
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // transfer register between integer side and fpu
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      xfer_r <= `FRF_XFER_RESET;
    end else if (xferLoadOk) begin
      xfer_r <= xferLoadData;                                   // RULE21
    end
  end

  // registered read answer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdValid_r <= 1'b0;
      rdData_r  <= 128'h0;
    end else begin
      rdValid_r <= rdEnOk;
      if (rdEnOk) begin
        rdData_r <= viewData;                                   // RULE2 RULE3
      end
    end
  end

  // refusal strobe
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      disableExc_r <= 1'b0;
    end else begin
      disableExc_r <= anyReq & fpuDisableBit;                   // RULE23
    end
  end

  // =====================================================================
  // outputs
  assign ctrlData   = ctrl_r;                                   // RULE11
  assign xferData   = xfer_r;                                   // RULE21
  assign rdValid    = rdValid_r;
  assign rdData     = rdData_r;
  assign disableExc = disableExc_r;

  // =====================================================================
  // checks
  default clocking cbDef @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  wire [8:0] rdPos   = {rdIdx, 5'h00};                          // bit offset of read index
  wire [8:0] evenPos = {wrReq.idx[3:1], 1'b0, 5'h00};           // bit offset of even reg
  wire       quiet   = !ctrlLoadOk && !bankToggleOk;            // no bank change this cycle

  a_reserved_zero: assert property (                            // RULE20
    ctrl_r[`FRF_RSVD_HI:`FRF_RSVD_LO] == 10'h000)
    else $error("reserved control bits not zero");

  a_reset_value: assert property (                              // RULE8
    @(posedge sys_clk) disable iff (1'b0) !nrst ##1 !nrst |-> ctrl_r == `FRF_CTRL_RESET)
    else $error("control not at reset value");

  a_cause_clear: assert property (                              // RULE17
    opStartOk && !excValidOk |=> ctrl_r[`FRF_CAUSE_HI:`FRF_CAUSE_LO] == 6'h00)
    else $error("cause not cleared at operation start");

  a_cause_mirror: assert property (                             // RULE18
    excValidOk |=> ctrl_r[`FRF_CAUSE_HI:`FRF_CAUSE_LO] == $past(excSrc))
    else $error("cause differs from reported sources");

  a_flag_sticky: assert property (                              // RULE18
    excValidOk |=> (ctrl_r[`FRF_FLAG_HI:`FRF_FLAG_LO] & $past(excSrc[4:0]))
                   == $past(excSrc[4:0]))
    else $error("flag not set by source");

  a_flag_hold: assert property (                                // RULE22
    !ctrlLoadOk |=> (ctrl_r[`FRF_FLAG_HI:`FRF_FLAG_LO] &
                     $past(ctrl_r[`FRF_FLAG_HI:`FRF_FLAG_LO]))
                    == $past(ctrl_r[`FRF_FLAG_HI:`FRF_FLAG_LO]))
    else $error("sticky flag lost");

  a_disable_refuse: assert property (                           // RULE23
    fpuDisableBit && anyReq |=> disableExc && !rdValid && ctrl_r == $past(ctrl_r))
    else $error("request accepted while fpu disabled");

  a_single_bank: assert property (                              // RULE2
    rdEnOk && rdView == frf_pkg::FRF_VIEW_SINGLE && !pairMove |=>
      rdData[31:0] == $past(bankSwap ? bank1Flat[rdPos +: 32] : bank0Flat[rdPos +: 32]))
    else $error("single view read from wrong bank");

  a_ext_bank: assert property (                                 // RULE3
    rdEnOk && rdView == frf_pkg::FRF_VIEW_EXT_SINGLE && !pairMove |=>
      rdData[31:0] == $past(bankSwap ? bank0Flat[rdPos +: 32] : bank1Flat[rdPos +: 32]))
    else $error("extended view read from wrong bank");

  a_double_write: assert property (                             // RULE4
    wrEnOk && wrReq.view == frf_pkg::FRF_VIEW_DOUBLE && !bankSwap && quiet |=>
      bank0Flat[$past(evenPos) +: 32] == $past(wrReq.data[63:32]))
    else $error("double write upper half misplaced");

  a_xfer_load: assert property (                                // RULE21
    xferLoadOk |=> xferData == $past(xferLoadData))
    else $error("transfer register not loaded");

  a_bank_toggle: assert property (                              // RULE24
    bankToggleOk && !ctrlLoadOk |=> bankSwap != $past(bankSwap))
    else $error("bank select did not flip");

  c_op_then_exc: cover property (opStartOk ##2 excValidOk && excSrc.inexact);
  c_refused: cover property (fpuDisableBit && anyReq);
  c_matrix_read: cover property (rdEnOk && rdView == frf_pkg::FRF_VIEW_MATRIX);
  c_pair_move: cover property (wrEnOk && pairMove &&
                               wrReq.view == frf_pkg::FRF_VIEW_SINGLE);

endmodule

/* frf_cfg.svh */
// constants for the floating-point register file and its control state
`ifndef FRF_CFG_SVH
`define FRF_CFG_SVH

// status/control field positions
`define FRF_BIT_BANK      21
`define FRF_BIT_SIZE      20
`define FRF_BIT_PREC      19
`define FRF_BIT_DENORM    18
`define FRF_CAUSE_HI      17
`define FRF_CAUSE_LO      12
`define FRF_ENABLE_HI     11
`define FRF_ENABLE_LO     7
`define FRF_FLAG_HI       6
`define FRF_FLAG_LO       2
`define FRF_RM_HI         1
`define FRF_RM_LO         0
`define FRF_RSVD_HI       31
`define FRF_RSVD_LO       22

// reset values and write mask
`define FRF_CTRL_RESET    32'h0004_0001
`define FRF_CTRL_WMASK    32'h003f_ffff
`define FRF_XFER_RESET    32'h0000_0000
`define FRF_FPR_RESET     32'h0000_0000

// rounding encodings
`define FRF_RM_NEAREST    2'h0
`define FRF_RM_ZERO       2'h1

`endif

/* frf_pkg.sv */
// types shared by the floating-point register file modules
package frf_pkg;

  // register view through which an instruction names its operand
  typedef enum logic [2:0] {
    FRF_VIEW_SINGLE     = 3'h0,
    FRF_VIEW_DOUBLE     = 3'h1,
    FRF_VIEW_VECTOR     = 3'h2,
    FRF_VIEW_EXT_SINGLE = 3'h3,
    FRF_VIEW_EXT_DOUBLE = 3'h4,
    FRF_VIEW_MATRIX     = 3'h5
  } frf_view_t;

  // register write request: 32-bit data in the low word, pairs use all 64
  typedef struct packed {
    frf_view_t   view;
    logic [3:0]  idx;
    logic [63:0] data;
  } frf_wr_req_t;

  // exception sources, error source in the top bit
  typedef struct packed {
    logic fpuError;
    logic invalid;
    logic divZero;
    logic overflow;
    logic underflow;
    logic inexact;
  } frf_exc_t;

  // decoded operating modes for the arithmetic side
  typedef struct packed {
    logic bankSwap;
    logic pairMove;
    logic doublePrec;
    logic flushDenorm;
    logic roundToZero;
    logic roundReserved;
    logic comboReserved;
  } frf_mode_t;

endpackage

/* frf_bank.sv */
// one bank of sixteen 32-bit physical floating-point registers
`timescale 1ns/1ps
`include "frf_cfg.svh"

module frf_bank (
  input  wire logic         sys_clk,     // core clock
  input  wire logic         nrst,        // async reset, active low
  input  wire logic         wrEvenEn,    // write the even register of the pair
  input  wire logic         wrOddEn,     // write the odd register of the pair
  input  wire logic [2:0]   wrPair,      // pair number
  input  wire logic [31:0]  wrEvenData,  // data for the even register
  input  wire logic [31:0]  wrOddData,   // data for the odd register
  output logic      [511:0] regsFlat     // all sixteen registers, reg i at [32i +: 32]
);

  // =====================================================================
  // storage
  logic [31:0] physicalFpReg [16];  // physical registers

  // pair-wise write, each half on its own enable
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) begin
        physicalFpReg[i] <= `FRF_FPR_RESET;
      end
    end else begin
      if (wrEvenEn) begin
        physicalFpReg[{wrPair, 1'b0}] <= wrEvenData;
      end
      if (wrOddEn) begin
        physicalFpReg[{wrPair, 1'b1}] <= wrOddData;
      end
    end
  end

  // flatten for the view selectors
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gFlat
      assign regsFlat[g*32 +: 32] = physicalFpReg[g];
    end
  endgenerate

endmodule

/* frf_view_sel.sv */
// gathers the words of one register view out of the two physical banks
`timescale 1ns/1ps

module frf_view_sel (
  input  wire logic              bankSwap,   // bank-select bit
  input  wire logic              pairMove,   // transfer-size bit
  input  wire frf_pkg::frf_view_t view,      // view being read
  input  wire logic [3:0]        idx,        // register or column number
  input  wire logic [511:0]      bank0Flat,  // bank 0 contents
  input  wire logic [511:0]      bank1Flat,  // bank 1 contents
  output logic      [127:0]      viewData    // gathered words, first word highest
);

  // =====================================================================
  // bank and base selection
  wire         isExt   = (view == frf_pkg::FRF_VIEW_EXT_SINGLE) ||
                         (view == frf_pkg::FRF_VIEW_EXT_DOUBLE) ||
                         (view == frf_pkg::FRF_VIEW_MATRIX);       // extended views
  wire         useBank1 = bankSwap ^ isExt;                        // opposite bank for extended
  wire [511:0] srcFlat  = useBank1 ? bank1Flat : bank0Flat;        // chosen bank
  wire         isQuad   = (view == frf_pkg::FRF_VIEW_VECTOR) ||
                          (view == frf_pkg::FRF_VIEW_MATRIX);      // four-word views
  wire         isPair   = (view == frf_pkg::FRF_VIEW_DOUBLE) ||
                          (view == frf_pkg::FRF_VIEW_EXT_DOUBLE) ||
                          (pairMove && !isQuad);                   // two-word views
  // matrix column k starts at extended register 4k, vectors at 0/4/8/12
  wire [3:0]   quadBase = (view == frf_pkg::FRF_VIEW_MATRIX) ? {idx[1:0], 2'h0}
                                                             : {idx[3:2], 2'h0};
  wire [3:0]   base     = isQuad ? quadBase : (isPair ? {idx[3:1], 1'b0} : idx);

  // consecutive words from the base
  wire [31:0]  w0 = srcFlat[{base, 5'h00} +: 32];
  wire [31:0]  w1 = srcFlat[{base[3:1], 1'b1, 5'h00} +: 32];
  wire [31:0]  w2 = srcFlat[{base[3:2], 2'h2, 5'h00} +: 32];
  wire [31:0]  w3 = srcFlat[{base[3:2], 2'h3, 5'h00} +: 32];

  // pack: even register is the upper half of a pair, row 0 highest in a column
  assign viewData = isQuad ? {w0, w1, w2, w3} :
                    isPair ? {64'h0, w0, w1} : {96'h0, w0};

endmodule

/* frf_cpu_model.sv */
// behavioural cpu side that issues register file requests
`timescale 1ns/1ps

module frf_cpu_model (
  input  wire logic           sys_clk,       // core clock
  output logic                fpuDisableBit, // processor fpu-disable bit
  output logic                opStart,       // operation begins
  output logic                excValid,      // operation reports sources
  output frf_pkg::frf_exc_t   excSrc,        // sources that occurred
  output logic                wrEn,          // register write
  output frf_pkg::frf_wr_req_t wrReq,        // write view, index, data
  output logic                rdEn,          // register read
  output frf_pkg::frf_view_t  rdView,        // read view
  output logic      [3:0]     rdIdx,         // read index
  output logic                ctrlLoad,      // status/control load
  output logic      [31:0]    ctrlLoadData,  // status/control value
  output logic                xferLoad,      // transfer register load
  output logic      [31:0]    xferLoadData,  // transfer value
  output logic                bankToggle     // flip bank-select bit
);
  // ==========================================
  // idle state at time zero
  initial begin
    {fpuDisableBit, opStart, excValid, wrEn, rdEn, ctrlLoad, xferLoad, bankToggle} = 8'h00;
    excSrc = '0;
    wrReq = '0;
    rdView = frf_pkg::FRF_VIEW_SINGLE;
    rdIdx = 4'h0;
    ctrlLoadData = 32'h0000_0000;
    xferLoadData = 32'h0000_0000;
  end

  // ==========================================
  // fpu-disable level, changed just after an edge
  task automatic setDisable(input logic b);
    @(posedge sys_clk);
    fpuDisableBit <= b;
  endtask

  // one-cycle request; strobes {wr,rd,ld,xf,tg,op,ex}, shared data word
  task automatic issue(input logic [6:0] s, input frf_pkg::frf_view_t v,
                       input logic [3:0] i, input logic [63:0] d);
    @(posedge sys_clk);
    {wrEn, rdEn, ctrlLoad, xferLoad, bankToggle, opStart, excValid} <= s;
    wrReq <= '{view: v, idx: i, data: d};
    rdView <= v;
    rdIdx <= i;
    ctrlLoadData <= {10'h000, d[21:20], d[19] & ~d[20], d[18:0]};
    xferLoadData <= d[31:0];
    excSrc <= frf_pkg::frf_exc_t'(d[5:0]);
    @(posedge sys_clk);
    {wrEn, rdEn, ctrlLoad, xferLoad, bankToggle, opStart, excValid} <= 7'h00;
    wrReq.data <= ~d; // released data shows no stale value
    xferLoadData <= ~d[31:0];
    #1;
  endtask
endmodule

/* frf_top_bench.sv */
// self-checking bench for the floating-point register file
`timescale 1ns/1ps

module frf_top_bench;
  localparam logic [6:0] S_WR = 7'h40, S_RD = 7'h20, S_LD = 7'h10, S_XF = 7'h08;
  localparam logic [6:0] S_TG = 7'h04, S_OP = 7'h02, S_EX = 7'h01;
  localparam frf_pkg::frf_view_t VS = frf_pkg::FRF_VIEW_SINGLE;
  localparam frf_pkg::frf_view_t VD = frf_pkg::FRF_VIEW_DOUBLE;
  localparam logic [63:0] Z = 64'h0;
  logic                 sys_clk, nrst;           // clock and reset
  int                   fails, checks_done;      // counters
  logic                 fpuDisableBit, opStart, excValid, wrEn, rdEn; // requests
  logic                 ctrlLoad, xferLoad, bankToggle, rdValid, disableExc; // strobes
  frf_pkg::frf_exc_t    excSrc;                  // exception sources
  frf_pkg::frf_wr_req_t wrReq;                   // write request
  frf_pkg::frf_view_t   rdView;                  // read view
  logic [3:0]           rdIdx;                   // read index
  logic [31:0]          ctrlLoadData, xferLoadData, ctrlData, xferData; // words
  logic [127:0]         rdData;                  // read data
  frf_pkg::frf_mode_t   mode;                    // decoded modes

  // ==========================================
  // design and cpu model
  frf_top DUT (.sys_clk(sys_clk), .nrst(nrst), .fpuDisableBit(fpuDisableBit),
    .opStart(opStart), .excValid(excValid), .excSrc(excSrc), .wrEn(wrEn), .wrReq(wrReq),
    .rdEn(rdEn), .rdView(rdView), .rdIdx(rdIdx), .ctrlLoad(ctrlLoad),
    .ctrlLoadData(ctrlLoadData), .xferLoad(xferLoad), .xferLoadData(xferLoadData),
    .bankToggle(bankToggle), .rdValid(rdValid), .rdData(rdData), .ctrlData(ctrlData),
    .xferData(xferData), .mode(mode), .disableExc(disableExc));
  frf_cpu_model cpu (.sys_clk(sys_clk), .fpuDisableBit(fpuDisableBit), .opStart(opStart),
    .excValid(excValid), .excSrc(excSrc), .wrEn(wrEn), .wrReq(wrReq), .rdEn(rdEn),
    .rdView(rdView), .rdIdx(rdIdx), .ctrlLoad(ctrlLoad), .ctrlLoadData(ctrlLoadData),
    .xferLoad(xferLoad), .xferLoadData(xferLoadData), .bankToggle(bankToggle));

  // ==========================================
  // compare, read and closing helpers
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rdChk(input frf_pkg::frf_view_t v, input logic [3:0] i,
                       input logic [127:0] exp, input string what);
    cpu.issue(S_RD, v, i, Z);
    chk(rdValid, 1'b1, what);
    chk(rdData, exp, what);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset;
    chk(ctrlData, 32'h0004_0001, "ctrl reset");
    chk({mode.flushDenorm, mode.roundToZero}, 2'b11, "reset modes");
  endtask

  task automatic t_banks;
    cpu.issue(S_WR, VS, 4'h3, 64'h1111_1111);
    cpu.issue(S_TG, VS, 4'h0, Z);
    chk({mode.bankSwap, ctrlData[21]}, 2'b11, "bank bit");
    cpu.issue(S_WR, VS, 4'h3, 64'h2222_2222);
    rdChk(VS, 4'h3, 128'h2222_2222, "single bank");
    rdChk(frf_pkg::FRF_VIEW_EXT_SINGLE, 4'h3, 128'h1111_1111, "ext bank");
  endtask

  task automatic t_views;
    cpu.issue(S_WR, VD, 4'h4, 64'haaaa_aaaa_bbbb_bbbb);
    rdChk(VD, 4'h4, 128'haaaa_aaaa_bbbb_bbbb, "double");
    rdChk(VS, 4'h5, 128'hbbbb_bbbb, "odd half");
    rdChk(frf_pkg::FRF_VIEW_VECTOR, 4'h4, {64'haaaa_aaaa_bbbb_bbbb, Z}, "vector");
    cpu.issue(S_WR, frf_pkg::FRF_VIEW_EXT_DOUBLE, 4'h0, 64'hcccc_cccc_dddd_dddd);
    rdChk(frf_pkg::FRF_VIEW_EXT_DOUBLE, 4'h0, 128'hcccc_cccc_dddd_dddd, "ext pair");
    rdChk(frf_pkg::FRF_VIEW_MATRIX, 4'h0, 128'hcccc_cccc_dddd_dddd_0000_0000_1111_1111,
          "col");
  endtask

  task automatic t_ctrl;
    cpu.issue(S_LD, VS, 4'h0, 64'h0030_0f81);
    chk(ctrlData, 32'h0030_0f81, "ctrl load");
    chk(mode.pairMove, 1'b1, "pair move");
    cpu.issue(S_WR, VS, 4'h6, 64'h5555_5555_6666_6666);
    rdChk(VD, 4'h6, 128'h5555_5555_6666_6666, "pair write");
    rdChk(VS, 4'h4, 128'haaaa_aaaa_bbbb_bbbb, "pair single");
    cpu.issue(S_LD, VS, 4'h0, 64'h0028_0002);
    chk({mode.doublePrec, mode.flushDenorm, mode.roundToZero, mode.roundReserved},
        4'b1001, "modes");
  endtask

  task automatic t_exc;
    cpu.issue(S_OP, VS, 4'h0, Z);
    cpu.issue(S_EX, VS, 4'h0, 64'h21);
    chk(ctrlData, 32'h002a_1006, "cause and flag");
    cpu.issue(S_OP, VS, 4'h0, Z);
    chk(ctrlData, 32'h0028_0006, "cause cleared");
    cpu.issue(S_EX, VS, 4'h0, 64'h10);
    chk(ctrlData, 32'h0029_0046, "sticky flags");
  endtask

  task automatic t_xfer_disable;
    cpu.issue(S_XF, VS, 4'h0, 64'hdead_beef);
    chk(xferData, 32'hdead_beef, "xfer load");
    cpu.setDisable(1'b1);
    cpu.issue(S_RD | S_XF, VS, 4'h3, 64'h1234_5678);
    chk({rdValid, disableExc}, 2'b01, "refused");
    chk(xferData, 32'hdead_beef, "xfer kept");
    cpu.setDisable(1'b0);
  endtask

  // ==========================================
  // clock, main sequence and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    fails = 0;
    checks_done = 0;
    nrst = 1'b0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    #1;
    t_reset;
    t_banks;
    t_views;
    t_ctrl;
    t_exc;
    t_xfer_disable;
    end_of_test;
  end

  initial begin
    repeat (2000) @(posedge sys_clk);
    fails++;
    end_of_test;
  end
endmodule
